// *** core/acc_ctrl.sv ***
// Purpose: Ambient calibration control registers and sequence control
// Assumes: Register port strobes come from logic on the same clock
// Notes: Calibration and filter decisions are taken at sequence end

`timescale 1ns/100ps

// Behaviour
// - Full power averaging skips 3/7/15/31
// - Low power averaging skips 0/1/2/3
// - Fast filter admits one, drops N
// - Full power hold: count x16 sequences
// - Low power hold: count x4 sequences
// - Power drop after scaled full-power count
// - Forced bit recalibrates every stage of the sequence
// - Restart bit returns to first stage, clears
// - Sequence converts N+1 stages, max twelve
// - Mode 00 full, 10 low, else shutdown
module acc_ctrl #(
    parameter int STAGE_CYCLES = acc_pkg::STAGE_CYCLES,
    parameter int STAGES = 12
) (
    input wire logic clock,
    input wire logic sys_rst,
    input wire logic [9:0] reg_addr,
    input wire logic reg_wr,
    input wire logic reg_rd,
    input wire logic [15:0] reg_wdata,
    output logic [15:0] reg_rdata,
    output logic reg_rvalid,
    input wire logic prox_detect,
    output logic [3:0] stage_index,
    output logic stage_start,
    output logic sequence_done,
    output logic [11:0] cal_update,
    output logic fifo_admit,
    output logic cal_hold,
    output logic low_power_active
);

    typedef enum logic [0:0] {ACC_SEQ_IDLE, ACC_SEQ_RUN} acc_seq_e;
    localparam int TW = acc_pkg::TIMER_W;
    localparam int DW = $clog2(STAGE_CYCLES + 1);

    if (STAGE_CYCLES < 1 || STAGES != 12) begin : g_chk
        $error("acc_ctrl: unsupported STAGE_CYCLES or STAGES");
    end

    function automatic logic [4:0] fp_skip(input logic [1:0] code);
        fp_skip = 5'((6'h04 << code) - 6'h01);
    endfunction

    // ---------------------------------------------------------------
    // Register bank
    // ---------------------------------------------------------------
    logic [15:0] pwr_ff, cal_en_ff, ctrl0_ff, rdata_ff;
    logic [15:0] nxt_pwr, nxt_cal_en, nxt_ctrl0, nxt_rdata;
    logic rvalid_ff;
    logic soft_rst, restart_wr;

    assign soft_rst = reg_wr && reg_addr == acc_pkg::PWR_CTRL_OFS
                      && reg_wdata[acc_pkg::SOFT_RST_BIT];
    assign restart_wr = reg_wr && reg_addr == acc_pkg::AMB_CTRL0_OFS
                        && reg_wdata[acc_pkg::RESTART_BIT];

    always_comb begin
        nxt_pwr = pwr_ff;
        nxt_cal_en = cal_en_ff;
        nxt_ctrl0 = ctrl0_ff;
        nxt_ctrl0[acc_pkg::RESTART_BIT] = 1'b0;
        if (soft_rst) begin
            nxt_pwr = acc_pkg::PWR_CTRL_RST;
            nxt_cal_en = acc_pkg::CAL_EN_RST;
            nxt_ctrl0 = acc_pkg::AMB_CTRL0_RST;
        end else if (reg_wr) begin
            unique case (reg_addr)
                acc_pkg::PWR_CTRL_OFS: begin
                    nxt_pwr = reg_wdata & acc_pkg::PWR_CTRL_WMASK;
                end
                acc_pkg::CAL_EN_OFS: begin
                    nxt_cal_en = reg_wdata;
                end
                acc_pkg::AMB_CTRL0_OFS: begin
                    nxt_ctrl0 = reg_wdata;
                end
                default: begin
                end
            endcase
        end
        nxt_rdata = 16'h0000;
        unique case (reg_addr)
            acc_pkg::PWR_CTRL_OFS: nxt_rdata = pwr_ff;
            acc_pkg::CAL_EN_OFS: nxt_rdata = cal_en_ff;
            acc_pkg::AMB_CTRL0_OFS: nxt_rdata = ctrl0_ff;
            default: nxt_rdata = 16'h0000;
        endcase
        if (!reg_rd) begin
            nxt_rdata = rdata_ff;
        end
    end

    always_ff @(posedge clock) begin
        if (sys_rst) begin
            pwr_ff <= acc_pkg::PWR_CTRL_RST;
            cal_en_ff <= acc_pkg::CAL_EN_RST;
            ctrl0_ff <= acc_pkg::AMB_CTRL0_RST;
            rdata_ff <= 16'h0000;
            rvalid_ff <= 1'b0;
        end else begin
            pwr_ff <= nxt_pwr;
            cal_en_ff <= nxt_cal_en;
            ctrl0_ff <= nxt_ctrl0;
            rdata_ff <= nxt_rdata;
            rvalid_ff <= reg_rd;
        end
    end

    assign reg_rdata = rdata_ff;
    assign reg_rvalid = rvalid_ff;

    // ---------------------------------------------------------------
    // Field decode
    // ---------------------------------------------------------------
    logic [1:0] mode, fp_code, lp_code, drop_code;
    logic [3:0] seq_len, last_stage, ff_n, fp_hold, lp_hold;
    logic conv_on, restart, forced, full_active;
    logic [11:0] stage_mask;
    logic drop_busy, hold_busy;
    logic [TW-1:0] hold_cnt, drop_cnt, hold_val, drop_val;

    assign mode = pwr_ff[acc_pkg::MODE_LSB +: 2];
    assign seq_len = pwr_ff[acc_pkg::SEQ_LEN_LSB +: 4];
    assign fp_code = cal_en_ff[acc_pkg::FP_SKIP_LSB +: 2];
    assign lp_code = cal_en_ff[acc_pkg::LP_SKIP_LSB +: 2];
    assign fp_hold = ctrl0_ff[acc_pkg::FP_HOLD_LSB +: 4];
    assign lp_hold = ctrl0_ff[acc_pkg::LP_HOLD_LSB +: 4];
    assign drop_code = ctrl0_ff[acc_pkg::DROP_LSB +: 2];
    assign forced = ctrl0_ff[acc_pkg::FORCE_BIT];
    assign restart = ctrl0_ff[acc_pkg::RESTART_BIT];
    // codes above the legal top are clamped
    assign ff_n = (ctrl0_ff[acc_pkg::FF_SKIP_LSB +: 4] > acc_pkg::MAX_FF_SKIP)
                  ? acc_pkg::MAX_FF_SKIP : ctrl0_ff[acc_pkg::FF_SKIP_LSB +: 4];
    assign last_stage = (seq_len > acc_pkg::MAX_STAGE)
                        ? acc_pkg::MAX_STAGE : seq_len;
    assign stage_mask = 12'((13'h0002 << last_stage) - 13'h0001);
    // only full and low power convert
    assign conv_on = (mode == acc_pkg::MODE_FULL)
                     || (mode == acc_pkg::MODE_LOW);
    assign full_active = (mode == acc_pkg::MODE_FULL)
                         || (mode == acc_pkg::MODE_LOW && drop_busy);

    // ---------------------------------------------------------------
    // Conversion sequencer
    // ---------------------------------------------------------------
    acc_seq_e state_ff, nxt_state;
    logic [DW-1:0] div_ff, nxt_div;
    logic [3:0] stage_ff, nxt_stage, idx_ff, nxt_idx;
    logic [4:0] avg_ff, nxt_avg, avg_skip;
    logic [3:0] ff_ff, nxt_ff;
    logic [11:0] upd_ff, nxt_upd;
    logic start_ff, done_ff, admit_ff, chold_ff, lp_ff;
    logic tick, conv_ev, seq_end, avg_take;

    assign tick = (div_ff == DW'(STAGE_CYCLES - 1));
    assign conv_ev = state_ff == ACC_SEQ_RUN && tick && !restart;
    assign seq_end = conv_ev && stage_ff == last_stage;
    // skip count by active power level
    assign avg_skip = full_active ? fp_skip(fp_code) : {3'h0, lp_code};
    assign avg_take = avg_ff >= avg_skip;

    always_comb begin
        nxt_state = conv_on ? ACC_SEQ_RUN : ACC_SEQ_IDLE;
        nxt_div = (tick || !conv_on) ? '0 : div_ff + 1'b1;
        nxt_stage = stage_ff;
        nxt_idx = idx_ff;
        nxt_avg = avg_ff;
        nxt_ff = ff_ff;
        nxt_upd = 12'h000;
        if (restart || state_ff == ACC_SEQ_IDLE) begin
            nxt_stage = 4'h0;
            nxt_ff = 4'h0;
        end else if (conv_ev) begin
            nxt_idx = stage_ff;
            nxt_stage = (stage_ff >= last_stage) ? 4'h0 : stage_ff + 4'h1;
        end
        if (seq_end) begin
            nxt_avg = avg_take ? 5'h00 : avg_ff + 5'h01;
            nxt_ff = (ff_ff == 4'h0) ? ff_n : ff_ff - 4'h1;
            if (forced) begin
                nxt_upd = stage_mask;
            end else if (avg_take && !(hold_busy || prox_detect)) begin
                nxt_upd = cal_en_ff[11:0] & stage_mask;
            end
        end
    end

    always_ff @(posedge clock) begin
        if (sys_rst || soft_rst) begin
            state_ff <= ACC_SEQ_IDLE;
            div_ff <= '0;
            stage_ff <= 4'h0;
            idx_ff <= 4'h0;
            avg_ff <= 5'h00;
            ff_ff <= 4'h0;
            upd_ff <= 12'h000;
            start_ff <= 1'b0;
            done_ff <= 1'b0;
            admit_ff <= 1'b0;
            chold_ff <= 1'b0;
            lp_ff <= 1'b0;
        end else begin
            state_ff <= nxt_state;
            div_ff <= nxt_div;
            stage_ff <= nxt_stage;
            idx_ff <= nxt_idx;
            avg_ff <= nxt_avg;
            ff_ff <= nxt_ff;
            upd_ff <= nxt_upd;
            start_ff <= conv_ev;
            done_ff <= seq_end;
            admit_ff <= seq_end && ff_ff == 4'h0;
            chold_ff <= hold_busy || prox_detect;
            lp_ff <= mode == acc_pkg::MODE_LOW && !drop_busy;
        end
    end

    assign stage_index = idx_ff;
    assign stage_start = start_ff;
    assign sequence_done = done_ff;
    assign cal_update = upd_ff;
    assign fifo_admit = admit_ff;
    assign cal_hold = chold_ff;
    assign low_power_active = lp_ff;

    // ---------------------------------------------------------------
    // Calibration hold and power drop timers
    // ---------------------------------------------------------------
    // hold length in sequences
    assign hold_val = full_active
        ? TW'(fp_hold) * TW'(acc_pkg::FP_HOLD_MULT)
        : TW'(lp_hold) * TW'(acc_pkg::LP_HOLD_MULT);
    // x16 scaled by 1.25..2.00 is x20..x32
    assign drop_val = TW'(fp_hold) * (TW'(20) + TW'(4) * TW'(drop_code));

    acc_hold_timer #(.WIDTH(TW)) u_hold (
        .clock(clock),
        .sys_rst(sys_rst),
        .clear(soft_rst),
        .load(prox_detect),
        .load_value(hold_val),
        .step(seq_end),
        .count(hold_cnt),
        .busy(hold_busy)
    );

    acc_hold_timer #(.WIDTH(TW)) u_drop (
        .clock(clock),
        .sys_rst(sys_rst),
        .clear(soft_rst),
        .load(prox_detect),
        .load_value(drop_val),
        .step(seq_end),
        .count(drop_cnt),
        .busy(drop_busy)
    );

    // ---------------------------------------------------------------
    // Assertions
    // ---------------------------------------------------------------
    default clocking cb @(posedge clock); endclocking
    default disable iff (sys_rst);

    restart_clears_a: assert property (
        restart && !restart_wr |=> !restart)
        else $error("restart bit did not clear");
    restart_stage_a: assert property (
        restart |=> stage_ff == 4'h0 && !start_ff)
        else $error("restart did not return to first stage");
    shutdown_idle_a: assert property (
        mode[0] ##1 mode[0] |=> !start_ff)
        else $error("conversion started in shutdown");
    seq_length_a: assert property (
        done_ff |-> idx_ff == $past(last_stage))
        else $error("sequence ended at wrong stage");
    fifo_admit_a: assert property (
        done_ff |-> admit_ff == ($past(ff_ff) == 4'h0))
        else $error("fast filter admit wrong");
    cal_enable_a: assert property (
        done_ff && !$past(forced) |->
        (upd_ff & ~$past(cal_en_ff[11:0])) == 12'h000)
        else $error("disabled stage calibrated");
    forced_all_a: assert property (
        done_ff && $past(forced) |-> upd_ff == $past(stage_mask))
        else $error("forced calibration missed a stage");
    hold_blocks_a: assert property (
        done_ff && $past(hold_busy && !forced) |-> upd_ff == 12'h000)
        else $error("calibration during hold");
    fp_hold_a: assert property (
        prox_detect && full_active && !soft_rst |=>
        hold_cnt == TW'($past(fp_hold)) * TW'(16))
        else $error("full power hold length wrong");
    lp_hold_a: assert property (
        prox_detect && !full_active && !soft_rst |=>
        hold_cnt == TW'($past(lp_hold)) * TW'(4))
        else $error("low power hold length wrong");
    drop_time_a: assert property (
        prox_detect && !soft_rst |=> drop_cnt == TW'($past(fp_hold))
        * (TW'(20) + TW'(4) * TW'($past(drop_code))))
        else $error("power drop timeout wrong");
    avg_skip_a: assert property (
        done_ff && $past(full_active && avg_ff < fp_skip(fp_code)
        && !forced) |-> upd_ff == 12'h000)
        else $error("averaging skip not honoured");
    lp_skip_a: assert property (
        done_ff && $past(!full_active && avg_ff < {3'h0, lp_code}
        && !forced) |-> upd_ff == 12'h000)
        else $error("low power skip not honoured");

    seq_done_c: cover property (done_ff && admit_ff);
    forced_c: cover property (done_ff && upd_ff == 12'hFFF);
    drop_c: cover property ($fell(drop_busy) && mode == acc_pkg::MODE_LOW);

endmodule

// *** core/acc_hold_timer.sv ***
// Purpose: Sequence-counting down timer for hold and timeout periods
// Assumes: Load has priority over step
// Notes: Busy while the count is non-zero

`timescale 1ns/100ps

module acc_hold_timer #(
    parameter int WIDTH = acc_pkg::TIMER_W
) (
    input wire logic clock,
    input wire logic sys_rst,
    input wire logic clear,
    input wire logic load,
    input wire logic [WIDTH-1:0] load_value,
    input wire logic step,
    output logic [WIDTH-1:0] count,
    output logic busy
);

    logic [WIDTH-1:0] cnt_ff;
    logic [WIDTH-1:0] nxt_cnt;

    if (WIDTH < 1) begin : g_chk
        $error("acc_hold_timer: WIDTH must be at least 1");
    end

    always_comb begin
        nxt_cnt = cnt_ff;
        if (clear) begin
            nxt_cnt = '0;
        end else if (load) begin
            nxt_cnt = load_value;
        end else if (step && cnt_ff != '0) begin
            nxt_cnt = cnt_ff - 1'b1;
        end
    end

    always_ff @(posedge clock) begin
        if (sys_rst) begin
            cnt_ff <= '0;
        end else begin
            cnt_ff <= nxt_cnt;
        end
    end

    assign count = cnt_ff;
    assign busy = (cnt_ff != '0);

endmodule

// *** core/acc_pkg.sv ***
// Purpose: Shared constants for the ambient calibration control bank
// Assumes: 16-bit registers on a 10-bit register address
// Notes: Offsets, field positions, reset values and cycle counts

package acc_pkg;

    // ---------------------------------------------------------------
    // Register map
    // ---------------------------------------------------------------
    localparam int ADDR_W = 10;
    localparam int DATA_W = 16;
    localparam logic [9:0] PWR_CTRL_OFS = 10'h000;
    localparam logic [9:0] CAL_EN_OFS = 10'h001;
    localparam logic [9:0] AMB_CTRL0_OFS = 10'h002;

    // ---------------------------------------------------------------
    // Field positions
    // ---------------------------------------------------------------
    localparam int MODE_LSB = 0;
    localparam int SEQ_LEN_LSB = 4;
    localparam int SOFT_RST_BIT = 10;
    localparam int FP_SKIP_LSB = 12;
    localparam int LP_SKIP_LSB = 14;
    localparam int FF_SKIP_LSB = 0;
    localparam int FP_HOLD_LSB = 4;
    localparam int LP_HOLD_LSB = 8;
    localparam int DROP_LSB = 12;
    localparam int FORCE_BIT = 14;
    localparam int RESTART_BIT = 15;

    // ---------------------------------------------------------------
    // Reset values and write masks
    // ---------------------------------------------------------------
    localparam logic [15:0] PWR_CTRL_RST = 16'h0000;
    localparam logic [15:0] CAL_EN_RST = 16'h0000;
    localparam logic [15:0] AMB_CTRL0_RST = 16'h0FF0;
    // Unused bit 13 and self-clearing bit 10 never store
    localparam logic [15:0] PWR_CTRL_WMASK = 16'hDBFF;

    // ---------------------------------------------------------------
    // Modes and limits
    // ---------------------------------------------------------------
    localparam logic [1:0] MODE_FULL = 2'h0;
    localparam logic [1:0] MODE_LOW = 2'h2;
    localparam logic [3:0] MAX_STAGE = 4'hB;
    localparam logic [3:0] MAX_FF_SKIP = 4'hB;
    localparam int FP_HOLD_MULT = 16;
    localparam int LP_HOLD_MULT = 4;
    localparam int TIMER_W = 9;

    // ---------------------------------------------------------------
    // Conversion timing
    // ---------------------------------------------------------------
    localparam int CLK_PERIOD_NS = 10;
    localparam int STAGE_TIME_NS = 1000;
    localparam int STAGE_CYCLES = (STAGE_TIME_NS + CLK_PERIOD_NS - 1)
                                  / CLK_PERIOD_NS;

endpackage

// *** dv/acc_host_model.sv ***
// Purpose: Host processor model driving the register port
// Assumes: Requests launched on falling edges, one strobe cycle each
// Notes: Released bus shows the inverse of the last request

`timescale 1ns/100ps

module acc_host_model (
    input wire logic clock,
    output logic [9:0] reg_addr,
    output logic reg_wr,
    output logic reg_rd,
    output logic [15:0] reg_wdata
);
    initial begin
        reg_addr = 10'h000;
        reg_wr = 1'b0;
        reg_rd = 1'b0;
        reg_wdata = 16'h0000;
    end

    // Gap adds idle cycles so the host can be prompt or slow
    task automatic access(input logic wr, input logic [9:0] a,
                          input logic [15:0] d, input int gap);
        repeat (gap + 1) @(negedge clock);
        reg_addr = a;
        reg_wdata = d;
        reg_wr = wr;
        reg_rd = !wr;
        @(negedge clock);
        reg_wr = 1'b0;
        reg_rd = 1'b0;
        reg_addr = ~a;
        reg_wdata = ~d;
    endtask
endmodule

// *** dv/test_acc_ctrl.sv ***
// Purpose: Self-checking bench for the ambient calibration control bank
// Assumes: Short stage time, host model on the register port
// Notes: Read results are checked against a queue of expected values

`timescale 1ns/100ps

module test_acc_ctrl;
    logic clock = 1'b0;
    logic sys_rst = 1'b1;
    logic prox_detect = 1'b0;
    logic [9:0] reg_addr;
    logic reg_wr;
    logic reg_rd;
    logic [15:0] reg_wdata;
    logic [15:0] reg_rdata;
    logic reg_rvalid;
    logic [3:0] stage_index;
    logic stage_start;
    logic sequence_done;
    logic [11:0] cal_update;
    logic [11:0] last_cal;
    logic fifo_admit;
    logic cal_hold;
    logic low_power_active;
    logic [15:0] exp_q[$];
    logic [15:0] v;
    int fails = 0;
    int cmp_count = 0;
    int cycles = 0;
    int seed = 32'h5CC6;
    int n_cal;
    int n_adm;
    int k;
    int lens[3] = '{2, 11, 15};
    int ffs[4] = '{0, 2, 11, 15};

    always #5 clock = ~clock;

    acc_ctrl #(.STAGE_CYCLES(4), .STAGES(12)) dut (.clock(clock),
        .sys_rst(sys_rst), .reg_addr(reg_addr), .reg_wr(reg_wr),
        .reg_rd(reg_rd), .reg_wdata(reg_wdata), .reg_rdata(reg_rdata),
        .reg_rvalid(reg_rvalid), .prox_detect(prox_detect),
        .stage_index(stage_index), .stage_start(stage_start),
        .sequence_done(sequence_done), .cal_update(cal_update),
        .fifo_admit(fifo_admit), .cal_hold(cal_hold),
        .low_power_active(low_power_active));

    acc_host_model host (.clock(clock), .reg_addr(reg_addr),
        .reg_wr(reg_wr), .reg_rd(reg_rd), .reg_wdata(reg_wdata));

    // ---------------------------------------------------------------
    // Helpers
    // ---------------------------------------------------------------
    task automatic chk(input string what, input logic [15:0] seen,
                       input logic [15:0] exp);
        cmp_count++;
        if (seen !== exp) begin
            fails++;
            $display("BAD %s expected %h seen %h", what, exp, seen);
        end
    endtask

    task automatic results();
        $display("comparisons %0d mismatches %0d", cmp_count, fails);
        if (fails == 0 && cmp_count > 0)
            $display("STATUS OK");
        else
            $display("STATUS NOT OK");
        $finish;
    endtask

    task automatic wr(input logic [9:0] a, input logic [15:0] d);
        host.access(1'b1, a, d, $random(seed) & 1);
    endtask

    task automatic rd(input logic [9:0] a, input logic [15:0] e);
        exp_q.push_back(e);
        host.access(1'b0, a, 16'h0000, 0);
    endtask

    task automatic pulse();
        @(negedge clock);
        prox_detect = 1'b1;
        @(negedge clock);
        prox_detect = 1'b0;
    endtask

    // Counts sequence ends with their calibration and admit pulses
    task automatic seqs(input int n);
        n_cal = 0;
        n_adm = 0;
        while (n > 0) begin
            @(negedge clock);
            if (sequence_done === 1'b1) begin
                n--;
                if (cal_update !== 12'h000) begin
                    n_cal++;
                    last_cal = cal_update;
                end
                if (fifo_admit === 1'b1)
                    n_adm++;
            end
        end
    endtask

    task automatic stages(input int last);
        int j;
        int dn;
        dn = 0;
        @(negedge clock);
        while (!(stage_start === 1'b1 && stage_index === 4'(last)))
            @(negedge clock);
        for (j = 0; j < 2 * (last + 1); j++) begin
            do begin
                @(negedge clock);
                if (sequence_done === 1'b1)
                    dn++;
            end while (stage_start !== 1'b1);
            chk("stage index", 16'(stage_index), 16'(j % (last + 1)));
        end
        chk("sequence ends", 16'(dn), 16'h0002);
    endtask

    always @(negedge clock) begin
        if (reg_rvalid === 1'b1) begin
            if (exp_q.size() == 0)
                chk("unexpected read", 16'h0001, 16'h0000);
            else
                chk("read data", reg_rdata, exp_q.pop_front());
        end
    end

    always @(posedge clock) begin
        cycles++;
        if (cycles == 20000) begin
            fails++;
            results();
        end
    end

    // ---------------------------------------------------------------
    // Scenarios
    // ---------------------------------------------------------------
    initial begin
        repeat (10) @(negedge clock);
        sys_rst = 1'b0;
        rd(acc_pkg::PWR_CTRL_OFS, 16'h0000);
        rd(acc_pkg::CAL_EN_OFS, 16'h0000);
        rd(acc_pkg::AMB_CTRL0_OFS, 16'h0FF0);
        wr(10'h3FF, 16'hFFFF);
        rd(10'h3FF, 16'h0000);
        repeat (4) begin
            v = 16'($random(seed));
            wr(acc_pkg::CAL_EN_OFS, v);
            rd(acc_pkg::CAL_EN_OFS, v);
            wr(acc_pkg::AMB_CTRL0_OFS, v & 16'h7FFF);
            rd(acc_pkg::AMB_CTRL0_OFS, v & 16'h7FFF);
            wr(acc_pkg::PWR_CTRL_OFS, v & acc_pkg::PWR_CTRL_WMASK);
            rd(acc_pkg::PWR_CTRL_OFS, v & acc_pkg::PWR_CTRL_WMASK);
        end
        wr(acc_pkg::PWR_CTRL_OFS, 16'h0400);
        rd(acc_pkg::AMB_CTRL0_OFS, 16'h0FF0);
        rd(acc_pkg::CAL_EN_OFS, 16'h0000);
        $display("test registers done");
        for (k = 1; k < 4; k += 2) begin
            wr(acc_pkg::PWR_CTRL_OFS, 16'(k));
            repeat (2) @(negedge clock);
            n_cal = 0;
            repeat (40) begin
                @(negedge clock);
                if (stage_start === 1'b1)
                    n_cal++;
            end
            chk("shutdown starts", 16'(n_cal), 16'h0000);
        end
        foreach (lens[i]) begin
            wr(acc_pkg::PWR_CTRL_OFS, 16'(lens[i] << 4));
            stages(lens[i] > 11 ? 11 : lens[i]);
        end
        wr(acc_pkg::PWR_CTRL_OFS, 16'h0030);
        do @(negedge clock);
        while (!(stage_start === 1'b1 && stage_index === 4'h1));
        wr(acc_pkg::AMB_CTRL0_OFS, 16'h8FF0);
        do @(negedge clock);
        while (stage_start !== 1'b1);
        chk("restart stage", 16'(stage_index), 16'h0000);
        rd(acc_pkg::AMB_CTRL0_OFS, 16'h0FF0);
        $display("test sequencer done");
        // forced calibration of all twelve stages, enables off
        wr(acc_pkg::PWR_CTRL_OFS, 16'h00B0);
        wr(acc_pkg::AMB_CTRL0_OFS, 16'h4FF0);
        seqs(1);
        seqs(4);
        chk("forced count", 16'(n_cal), 16'h0004);
        chk("forced stages", 16'(last_cal), 16'h0FFF);
        wr(acc_pkg::AMB_CTRL0_OFS, 16'h0FF0);
        wr(acc_pkg::PWR_CTRL_OFS, 16'h0000);
        for (k = 0; k < 4; k++) begin
            wr(acc_pkg::CAL_EN_OFS, 16'h0FFF | 16'(k << 12));
            seqs(1);
            seqs(2 * (4 << k));
            chk("full skip", 16'(n_cal), 16'h0002);
            chk("full stage", 16'(last_cal), 16'h0001);
        end
        wr(acc_pkg::PWR_CTRL_OFS, 16'h0010);
        wr(acc_pkg::CAL_EN_OFS, 16'h0002);
        seqs(1);
        seqs(8);
        chk("enable stage", 16'(last_cal), 16'h0002);
        wr(acc_pkg::CAL_EN_OFS, 16'h0000);
        seqs(1);
        seqs(8);
        chk("disabled", 16'(n_cal), 16'h0000);
        wr(acc_pkg::PWR_CTRL_OFS, 16'h0002);
        for (k = 0; k < 4; k++) begin
            wr(acc_pkg::CAL_EN_OFS, 16'h0FFF | 16'(k << 14));
            seqs(1);
            seqs(2 * (k + 1));
            chk("low skip", 16'(n_cal), 16'h0002);
            chk("low active", 16'(low_power_active), 16'h0001);
        end
        $display("test calibration done");
        wr(acc_pkg::PWR_CTRL_OFS, 16'h0000);
        foreach (ffs[i]) begin
            wr(acc_pkg::AMB_CTRL0_OFS, 16'h8FF0 | 16'(ffs[i]));
            seqs(3 * ((ffs[i] > 11 ? 11 : ffs[i]) + 1));
            chk("filter admits", 16'(n_adm), 16'h0003);
        end
        wr(acc_pkg::CAL_EN_OFS, 16'h0FFF);
        wr(acc_pkg::AMB_CTRL0_OFS, 16'h0F10);
        pulse();
        seqs(14);
        chk("hold level", 16'(cal_hold), 16'h0001);
        chk("held updates", 16'(n_cal), 16'h0000);
        seqs(3);
        chk("hold ended", 16'(cal_hold), 16'h0000);
        seqs(8);
        chk("resumed", 16'(n_cal), 16'h0002);
        // low power hold of count x4 sequences
        wr(acc_pkg::PWR_CTRL_OFS, 16'h0002);
        wr(acc_pkg::AMB_CTRL0_OFS, 16'h0110);
        pulse();
        seqs(3);
        chk("low hold level", 16'(cal_hold), 16'h0001);
        seqs(2);
        chk("low hold ended", 16'(cal_hold), 16'h0000);
        for (k = 0; k < 4; k++) begin
            wr(acc_pkg::AMB_CTRL0_OFS, 16'h0F10 | 16'(k << 12));
            pulse();
            seqs(18 + 4 * k);
            chk("drop early", 16'(low_power_active), 16'h0000);
            seqs(4);
            chk("drop late", 16'(low_power_active), 16'h0001);
        end
        $display("test timers done");
        repeat (4) @(negedge clock);
        chk("pending reads", 16'(exp_q.size()), 16'h0000);
        results();
    end
endmodule
